// [pci_config_status_classcode.sv]
// configuration space slice: command enables, status flags, class code
// assumes bus events arrive as one-cycle pulses from the pci engine on clk
`timescale 1ns/1ps
`default_nettype none

// Operation
// - set bit 15 on address or data parity
// - set bit 14 when system fault signaled
// - set bit 13 on received master abort
// - set bit 12 on received target abort
// - set bit 11 when issuing target abort
// - set bit 8 on mastered parity, enabled
// - devsel timing field reads 01b
// - bit 7 reads zero
// - bit 6 reads zero
// - bit 5 reads zero
// - bit 4 reads one
// - bits 3 to 0 read zero
// - base class reads 0ch
// - subclass reads fixed serial bus code
// - programming interface reads 10h
// - revision byte read-only; writes ignored
// - command bit 6 enables parity signal drive
// - command bit 8 enables system fault driver
module pci_config_status_classcode
    import pci_cfg_pkg::*;
#(
    // arbitrary value, not a real part revision
    parameter logic [7:0] SILICON_REVISION = 8'h01
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // configuration access port
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWriteData,
    output logic [31:0] cfgReadData,
    output logic cfgReadValid,
    // bus events from the protocol engine
    input wire logic addressParityError,
    input wire logic dataParityError,
    input wire logic masterAbortReceived,
    input wire logic targetAbortReceived,
    input wire logic targetAbortIssued,
    input wire logic parityFaultAsserted,
    input wire logic actingAsMaster,
    // open-drain fault pins, low when driven
    output logic parityPinN_out,
    output logic parityPinN_oe,
    output logic systemFaultPinN_out,
    output logic systemFaultPinN_oe,
    // enables and status view seen by the rest of the device
    output logic parityResponseEnable,
    output logic systemFaultOutputEnable,
    output logic [15:0] statusView
);
    status_event_if statusEvents ();

    logic parityEnable_reg;
    logic systemFaultEnable_reg;
    logic [31:0] readData_reg;
    logic readValid_reg;
    logic parityDrive_reg;
    logic systemFaultDrive_reg;
    logic [15:0] statusView_reg;
    logic [15:0] setMask;
    logic [15:0] clearMask;
    logic systemFaultFire;
    logic parityFire;
    logic masterParityFault;

    // dword index compare ignores the byte lane bits
    function automatic logic hitsDword(input logic [7:0] addr, input logic [7:0] base);
        hitsDword = (addr[7:2] == base[7:2]);
    endfunction

    function automatic logic [31:0] classWord(input logic [7:0] revision);
        classWord = {FUNCTION_BASE_CATEGORY,
            FUNCTION_SUBCATEGORY,
            PROGRAMMING_MODEL_CODE,
            revision};
    endfunction

    function automatic logic [15:0] commandWord(input logic parityOn, input logic faultOn);
        commandWord = 16'h0000;
        commandWord[PARITY_RESPONSE_ENABLE_BIT] = parityOn;
        commandWord[SYSTEM_FAULT_OUTPUT_ENABLE_BIT] = faultOn;
    endfunction

    logic commandHit;
    logic classHit;
    assign commandHit = hitsDword(cfgAddr, COMMAND_OFFSET);
    assign classHit = hitsDword(cfgAddr, CLASS_OFFSET);

    // system fault goes out only on an address parity error while enabled
    assign systemFaultFire = addressParityError & systemFaultEnable_reg;
    // parity response only on data parity while enabled
    assign parityFire = dataParityError & parityEnable_reg;
    assign masterParityFault = parityFaultAsserted & actingAsMaster
        & parityEnable_reg;

    always_comb begin
        setMask = 16'h0000;
        setMask[PARITY_FAULT_SEEN_BIT] = addressParityError | dataParityError;
        setMask[SYSTEM_FAULT_SIGNALED_BIT] = systemFaultFire;
        setMask[MASTER_ABORT_RECEIVED_BIT] = masterAbortReceived;
        setMask[TARGET_ABORT_RECEIVED_BIT] = targetAbortReceived;
        setMask[TARGET_ABORT_ISSUED_BIT] = targetAbortIssued;
        setMask[MASTER_DATA_PARITY_FAULT_BIT] = masterParityFault;
    end

    // status sits in the upper half of the command dword, lanes 2 and 3
    always_comb begin
        clearMask = 16'h0000;
        if (cfgWrite && commandHit) begin
            if (cfgByteEn[2]) begin
                clearMask[7:0] = cfgWriteData[23:16];
            end
            if (cfgByteEn[3]) begin
                clearMask[15:8] = cfgWriteData[31:24];
            end
        end
    end

    assign statusEvents.setMask = setMask;
    assign statusEvents.clearMask = clearMask;

    status_flag_bank flagBank (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .events(statusEvents.sink)
    );

    // command enables; class dword has no writable bits at all
    always_ff @(posedge clk) begin
        if (reset) begin
            parityEnable_reg <= COMMAND_RESET[PARITY_RESPONSE_ENABLE_BIT];
            systemFaultEnable_reg <= COMMAND_RESET[SYSTEM_FAULT_OUTPUT_ENABLE_BIT];
        end else if (ce && cfgWrite && commandHit) begin
            if (cfgByteEn[0]) begin
                parityEnable_reg <= cfgWriteData[PARITY_RESPONSE_ENABLE_BIT];
            end
            if (cfgByteEn[1]) begin
                systemFaultEnable_reg <= cfgWriteData[SYSTEM_FAULT_OUTPUT_ENABLE_BIT];
            end
        end
    end

    // read answer one cycle after the request; unmapped dwords read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            readData_reg <= READ_UNMAPPED;
            readValid_reg <= 1'b0;
        end else if (ce) begin
            readValid_reg <= cfgRead;
            if (cfgRead) begin
                if (commandHit) begin
                    readData_reg <= {statusEvents.flags,
                        commandWord(parityEnable_reg, systemFaultEnable_reg)};
                end else if (classHit) begin
                    readData_reg <= classWord(SILICON_REVISION);
                end else begin
                    readData_reg <= READ_UNMAPPED;
                end
            end
        end
    end

    // pin drive lasts one clock per detected fault
    always_ff @(posedge clk) begin
        if (reset) begin
            parityDrive_reg <= 1'b0;
            systemFaultDrive_reg <= 1'b0;
        end else if (ce) begin
            parityDrive_reg <= parityFire;
            systemFaultDrive_reg <= systemFaultFire;
        end
    end

    // mirror so the status output leaves a flop of this module
    always_ff @(posedge clk) begin
        if (reset) begin
            statusView_reg <= STATUS_RESET;
        end else if (ce) begin
            statusView_reg <= statusEvents.flags;
        end
    end

    assign cfgReadData = readData_reg;
    assign cfgReadValid = readValid_reg;
    assign parityPinN_out = 1'b0;
    assign parityPinN_oe = parityDrive_reg;
    assign systemFaultPinN_out = 1'b0;
    assign systemFaultPinN_oe = systemFaultDrive_reg;
    assign parityResponseEnable = parityEnable_reg;
    assign systemFaultOutputEnable = systemFaultEnable_reg;
    assign statusView = statusView_reg;
endmodule
`default_nettype wire

// [pci_cfg_pkg.sv]
// constants for the configuration status and class code block
// assumes one pci clock domain and dword-wide configuration accesses
package pci_cfg_pkg;

    // byte offsets in configuration space
    localparam logic [7:0] COMMAND_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h06;
    localparam logic [7:0] CLASS_OFFSET = 8'h08;

    // command register bit positions
    localparam int PARITY_RESPONSE_ENABLE_BIT = 6;
    localparam int SYSTEM_FAULT_OUTPUT_ENABLE_BIT = 8;
    localparam logic [15:0] COMMAND_RESET = 16'h0000;

    // status register bit positions
    localparam int PARITY_FAULT_SEEN_BIT = 15;
    localparam int SYSTEM_FAULT_SIGNALED_BIT = 14;
    localparam int MASTER_ABORT_RECEIVED_BIT = 13;
    localparam int TARGET_ABORT_RECEIVED_BIT = 12;
    localparam int TARGET_ABORT_ISSUED_BIT = 11;
    localparam int DEVSEL_TIMING_LSB = 9;
    localparam int MASTER_DATA_PARITY_FAULT_BIT = 8;
    localparam int BACK_TO_BACK_CAPABLE_BIT = 7;
    localparam int USER_FEATURE_SUPPORT_BIT = 6;
    localparam int DOUBLE_SPEED_CAPABLE_BIT = 5;
    localparam int CAPABILITY_LIST_PRESENT_BIT = 4;

    localparam logic [1:0] DEVSEL_TIMING_MEDIUM = 2'h1;
    localparam logic BACK_TO_BACK_CAPABLE = 1'b0;
    localparam logic USER_FEATURE_SUPPORT = 1'b0;
    localparam logic DOUBLE_SPEED_CAPABLE = 1'b0;
    localparam logic CAPABILITY_LIST_PRESENT = 1'b1;
    localparam logic [3:0] STATUS_RESERVED_LOW = 4'h0;

    // sticky flags that software clears by writing one
    localparam logic [15:0] STATUS_STICKY_MASK = 16'hf900;
    localparam logic [15:0] STATUS_RESET = 16'h0210;

    // class code fields
    localparam logic [7:0] FUNCTION_BASE_CATEGORY = 8'h0c;
    localparam logic [7:0] FUNCTION_SUBCATEGORY = 8'h00;
    localparam logic [7:0] PROGRAMMING_MODEL_CODE = 8'h10;

    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

// [status_event_if.sv]
// carries sticky status events and software clears to the flag bank
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface status_event_if;
    logic [15:0] setMask;
    logic [15:0] clearMask;
    logic [15:0] flags;

    modport source (output setMask, output clearMask, input flags);
    modport sink (input setMask, input clearMask, output flags);
endinterface
`default_nettype wire

// [status_flag_bank.sv]
// sticky status flags with write-one-to-clear and hard-wired bits
// assumes set and clear masks are single-cycle pulses from the same clock
`timescale 1ns/1ps
`default_nettype none
module status_flag_bank
    import pci_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    status_event_if.sink events
);
    logic [15:0] sticky_reg;
    logic [15:0] sticky_next;

    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        sticky_next = ((sticky_reg & ~events.clearMask) | events.setMask)
            & STATUS_STICKY_MASK;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sticky_reg <= STATUS_RESET & STATUS_STICKY_MASK;
        end else if (ce) begin
            sticky_reg <= sticky_next;
        end
    end

    always_comb begin
        events.flags = sticky_reg;
        events.flags[DEVSEL_TIMING_LSB +: 2] = DEVSEL_TIMING_MEDIUM;
        events.flags[BACK_TO_BACK_CAPABLE_BIT] = BACK_TO_BACK_CAPABLE;
        events.flags[USER_FEATURE_SUPPORT_BIT] = USER_FEATURE_SUPPORT;
        events.flags[DOUBLE_SPEED_CAPABLE_BIT] = DOUBLE_SPEED_CAPABLE;
        events.flags[CAPABILITY_LIST_PRESENT_BIT] = CAPABILITY_LIST_PRESENT;
        events.flags[3:0] = STATUS_RESERVED_LOW;
    end
endmodule
`default_nettype wire

// [pci_status_chk.sv]
// checker on the status and class code block ports
// assumes a single clock; ce stays high around every fault event
`timescale 1ns/1ps
`default_nettype none
module pci_status_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWriteData,
    input wire logic addressParityError,
    input wire logic dataParityError,
    input wire logic parityFaultAsserted,
    input wire logic actingAsMaster,
    input wire logic parityPinN_oe,
    input wire logic systemFaultPinN_oe,
    input wire logic parityResponseEnable,
    input wire logic systemFaultOutputEnable,
    input wire logic [15:0] statusView
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic apErr;
    logic mpErr;
    assign apErr = ce && addressParityError && systemFaultOutputEnable;
    assign mpErr = ce && parityFaultAsserted && actingAsMaster && parityResponseEnable;
    chk_parity_flag_set:
        assert property (ce && (addressParityError || dataParityError) |-> ##2 statusView[15])
        else $error("parity flag not set");
    chk_system_flag_set:
        assert property (apErr |-> ##2 statusView[14]) else $error("system flag not set");
    chk_system_pin_pulse:
        assert property (apErr ##1 (ce && !apErr) |-> systemFaultPinN_oe ##1 !systemFaultPinN_oe)
        else $error("system pin drive wrong");
    chk_system_pin_cause:
        assert property ($rose(systemFaultPinN_oe) |-> $past(apErr))
        else $error("system pin without cause");
    chk_parity_pin_drive:
        assert property (ce && dataParityError && parityResponseEnable |=> parityPinN_oe)
        else $error("parity pin not driven");
    chk_master_parity_set:
        assert property (mpErr |-> ##2 statusView[8]) else $error("bit 8 not set");
    chk_master_parity_cause:
        assert property ($rose(statusView[8]) |-> $past(mpErr, 2))
        else $error("bit 8 without cause");
    chk_fixed_bits:
        assert property ({statusView[10:9], statusView[7:0]} == 10'h110)
        else $error("fixed status bits wrong");
    chk_sticky_hold:
        assert property ($fell(statusView[15]) |->
            $past(cfgWrite && cfgByteEn[3] && cfgWriteData[31], 2))
        else $error("bit 15 fell without clear");
endmodule
bind pci_config_status_classcode pci_status_chk chk (.clk, .reset, .ce, .cfgWrite,
    .cfgByteEn, .cfgWriteData, .addressParityError, .dataParityError,
    .parityFaultAsserted, .actingAsMaster, .parityPinN_oe, .systemFaultPinN_oe,
    .parityResponseEnable, .systemFaultOutputEnable, .statusView);
`default_nettype wire

// [cfg_host_model.sv]
// host bridge model issuing configuration reads and writes
// assumes requests are taken on the rising edge after being raised
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input wire logic clk,
    output logic cfgRead,
    output logic cfgWrite,
    output logic [7:0] cfgAddr,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgWriteData,
    input wire logic [31:0] cfgReadData,
    input wire logic cfgReadValid
);
    initial begin
        cfgRead = 1'b0;
        cfgWrite = 1'b0;
        cfgAddr = 8'h00;
        cfgByteEn = 4'h0;
        cfgWriteData = 32'h0;
    end
    // ones clear sticky flags, zeros leave them
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        cfgWrite = 1'b1;
        cfgAddr = a;
        cfgByteEn = be;
        cfgWriteData = d;
        @(negedge clk);
        cfgWrite = 1'b0;
        // released lines stop showing the old value
        cfgAddr = ~a;
        cfgWriteData = ~d;
    endtask
    // the answer stands for one cycle only, so take it before releasing
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        cfgRead = 1'b1;
        cfgAddr = a;
        @(negedge clk);
        d = (cfgReadValid === 1'b1) ? cfgReadData : 32'hx;
        cfgRead = 1'b0;
        cfgAddr = ~a;
    endtask
endmodule
`default_nettype wire

// [pci_config_status_classcode_bench.sv]
// self-checking bench for the status and class code block
// assumes the host model runs all configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pci_config_status_classcode_bench;
    localparam logic [7:0] REV = 8'h5a; // arbitrary revision value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] ev = 7'h0;
    logic [31:0] rdData;
    logic [31:0] cfgReadData;
    logic [31:0] cfgWriteData;
    logic [7:0] cfgAddr;
    logic [3:0] cfgByteEn;
    logic cfgReadValid;
    logic cfgRead;
    logic cfgWrite;
    logic ce = 1'b1;
    logic parOut, parOe, sysOut, sysOe, parEn, sysEn;
    logic [15:0] statusView;
    int n_fail = 0;
    int checks = 0;
    always #10 clk = ~clk;
    cfg_host_model host (.clk, .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWriteData,
        .cfgReadData, .cfgReadValid);
    pci_config_status_classcode #(.SILICON_REVISION(REV)) dut (.clk, .reset, .ce,
        .cfgRead, .cfgWrite, .cfgAddr, .cfgByteEn, .cfgWriteData, .cfgReadData,
        .cfgReadValid, .addressParityError(ev[6]), .dataParityError(ev[5]),
        .masterAbortReceived(ev[4]), .targetAbortReceived(ev[3]),
        .targetAbortIssued(ev[2]), .parityFaultAsserted(ev[1]), .actingAsMaster(ev[0]),
        .parityPinN_out(parOut), .parityPinN_oe(parOe), .systemFaultPinN_out(sysOut),
        .systemFaultPinN_oe(sysOe), .parityResponseEnable(parEn),
        .systemFaultOutputEnable(sysEn), .statusView);
    task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, rdData);
        checks++;
        if (rdData !== exp) begin
            n_fail++;
            $display("MISMATCH reg %h expected %h seen %h", a, exp, rdData);
        end
    endtask
    task automatic chkVal(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(input logic [6:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 7'h0;
    endtask
    task automatic fixedFields;
        chkReg(8'h04, 32'h0210_0000);
        chkReg(8'h08, {24'h0c0010, REV});
        host.wr(8'h08, 4'hf, 32'hffff_ffff);
        chkReg(8'h08, {24'h0c0010, REV});
        host.wr(8'h04, 4'hc, 32'h06ff_0000);
        chkReg(8'h04, 32'h0210_0000);
        chkReg(8'h0c, 32'h0);
    endtask
    task automatic abortFlags;
        logic [15:0] f;
        for (int i = 2; i < 5; i++) begin
            f = 16'(1 << (i + 9));
            pulse(7'(1 << i));
            chkReg(8'h04, {16'h0210 | f, 16'h0});
            host.wr(8'h04, 4'hc, 32'h0);
            chkReg(8'h04, {16'h0210 | f, 16'h0});
            host.wr(8'h04, 4'hc, {f, 16'h0});
            chkReg(8'h04, 32'h0210_0000);
        end
    endtask
    task automatic parityFlags;
        pulse(7'h40);
        chkVal("pins", 16'h0000, {12'h000, parOe, parOut, sysOe, sysOut});
        chkReg(8'h04, 32'h8210_0000);
        pulse(7'h03);
        chkReg(8'h04, 32'h8210_0000);
        host.wr(8'h04, 4'h3, 32'h0000_ffff);
        chkVal("enables", 16'h0003, {14'h0000, parEn, sysEn});
        chkReg(8'h04, 32'h8210_0140);
        pulse(7'h40);
        chkVal("pins", 16'h0002, {12'h000, parOe, parOut, sysOe, sysOut});
        pulse(7'h20);
        chkVal("pins", 16'h0008, {12'h000, parOe, parOut, sysOe, sysOut});
        pulse(7'h02);
        chkReg(8'h04, 32'hc210_0140);
        pulse(7'h03);
        chkReg(8'h04, 32'hc310_0140);
        chkVal("status view", 16'hc310, statusView);
        host.wr(8'h04, 4'hc, 32'hf900_0000);
        chkReg(8'h04, 32'h0210_0140);
        chkVal("status view", 16'h0210, statusView);
    endtask
    task automatic resetAgain;
        // event and clear in one cycle: the event must win
        fork
            pulse(7'h10);
            host.wr(8'h04, 4'hc, 32'h2000_0000);
        join
        chkReg(8'h04, 32'h2210_0140);
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chkReg(8'h04, 32'h0210_0000);
    endtask
    task automatic frozen;
        @(negedge clk);
        ce = 1'b0;
        pulse(7'h10);
        host.wr(8'h04, 4'h1, 32'h0000_0040);
        chkVal("frozen view", 16'h0210, statusView);
        ce = 1'b1;
        chkReg(8'h04, 32'h0210_0000);
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        fixedFields();
        abortFlags();
        parityFlags();
        resetAgain();
        frozen();
        print_verdict();
    end
endmodule
`default_nettype wire
